// file: rtl/sacq_pkg.sv
package sacq_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SMP_W = 24;
  localparam int unsigned RAW_W = 26;
  localparam int unsigned CH_W = 3;
  localparam int unsigned LIST_MAX = 8;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned BUF_W = 16;
  localparam int unsigned QUE_W = 8;
  localparam int unsigned GRP_W = 6;
  localparam int unsigned THR_W = 7;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THRESH = 8'h04;
  localparam logic [7:0] REG_LIST_LEN = 8'h08;
  localparam logic [7:0] REG_LIST = 8'h0C;
  localparam logic [7:0] REG_BUF_LEN = 8'h10;
  localparam logic [7:0] REG_QUEUE = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  localparam int unsigned CTRL_VAR_LSB = 0;
  localparam int unsigned CTRL_TRG_LSB = 2;
  localparam int unsigned CTRL_SLAVE_BIT = 4;
  localparam int unsigned CMD_ARM_BIT = 0;
  localparam int unsigned CMD_START_BIT = 1;
  localparam int unsigned CMD_ORDERLY_BIT = 2;
  localparam int unsigned CMD_ABRUPT_BIT = 3;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_OVR_BIT = 2;
  localparam int unsigned ST_PART_BIT = 3;
  localparam int unsigned ST_CFGERR_BIT = 4;
  localparam int unsigned ST_QUE_LSB = 8;
  localparam int unsigned ST_SCAN_LSB = 16;

  // ---------------------------------------------------------------
  // variants, trigger sources, channel codes
  // ---------------------------------------------------------------
  localparam logic [1:0] VAR_BASE = 2'h0;
  localparam logic [1:0] VAR_AO = 2'h1;
  localparam logic [1:0] VAR_NOAO = 2'h2;
  localparam logic [3:0] LEN_BASE = 4'h5;
  localparam logic [3:0] LEN_AO = 4'h8;
  localparam logic [3:0] LEN_NOAO = 4'h7;
  localparam logic [2:0] CH_TACH0 = 3'h4;
  localparam logic [2:0] CH_TACH1 = 3'h5;
  localparam logic [2:0] CH_GATE2 = 3'h6;
  localparam logic [2:0] CH_AORB = 3'h7;
  localparam logic [1:0] TRG_SW = 2'h0;
  localparam logic [1:0] TRG_EXT = 2'h1;
  localparam logic [1:0] TRG_THR = 2'h2;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_LIST_LEN = 4'h5;
  localparam logic [23:0] RST_LIST = 24'h00_4688;
  localparam logic [15:0] RST_BUF_LEN = 16'h0100;
  localparam logic [6:0] RST_THR_STEPS = 7'h0A;
  localparam logic [GRP_W-1:0] GRP_DELAY = 6'h27;

  // threshold levels in millivolts, full scale +-10 V
  localparam longint FS_MV = 10000;
  localparam longint THR_FIXED_MV = 1000;
  localparam longint THR_STEP_MV = 100;
  localparam longint HYST_MV = 100;
  localparam logic [6:0] THR_MIN_STEPS = 7'h02;
  localparam logic [6:0] THR_MAX_STEPS = 7'h62;
  localparam logic [23:0] CODE_MID = 24'h80_0000;

endpackage

// file: rtl/sacq_ctrl.sv
`timescale 1ns/1ps

// Operation
// - base variant: at most five list entries
// - output variant: eight entries, code 7 readback
// - no-output variant: at most seven entries
// - codes 0-3 analog, 4-6 counters
// - entries delivered in programmed order
// - scans stored until buffers full or stop
// - one whole scan per sample pulse
// - orderly stop finishes buffer, ignores triggers
// - abrupt stop halts, returns partial buffer
// - start write is the software trigger
// - external trigger fires on rising edge
// - slave (not in base variant) takes trigger and clock from link
// - base threshold fixed at one volt
// - programmable threshold with 0.1 V hysteresis
// - threshold watches channel 0 always
// - analog samples coded offset binary, counters raw
// - out-of-range inputs saturate
// - buffer-done on each full buffer
// - buffers filled back to back, then stop
// - out of buffers: overrun event, stop
// - samples are fixed 24-bit words
// - first 39 sample pulses carry no data
module sacq_ctrl (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // pins
  input wire logic smp_clk_i,
  input wire logic ext_trig_i,
  input wire logic sync_trig_i,
  input wire logic sync_clk_i,
  // converters and counters
  input wire logic signed [25:0] adc0_i,
  input wire logic signed [25:0] adc1_i,
  input wire logic signed [25:0] adc2_i,
  input wire logic signed [25:0] adc3_i,
  input wire logic signed [25:0] ao_rb_i,
  input wire logic [23:0] tach0_i,
  input wire logic [23:0] tach1_i,
  input wire logic [23:0] gate2_i,
  // sample stream
  output logic smp_valid_o,
  output logic [23:0] smp_data_o,
  output logic [2:0] smp_chan_o,
  output logic smp_eos_o,
  // events
  output logic buf_done_o,
  output logic buf_part_o,
  output logic overrun_o,
  output logic busy_o
);

  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN, S_DONE} sacq_state_e;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // offset binary coding
  function automatic logic [23:0] sat24(input logic signed [25:0] raw);
    logic [23:0] res;
    res = 24'(raw) ^ sacq_pkg::CODE_MID;
    if (raw > 26'sh07F_FFFF) begin
      res = 24'hFF_FFFF;
    end else if (raw < -26'sh080_0000) begin
      res = 24'h00_0000;
    end
    return res;
  endfunction

  function automatic logic [23:0] mv_code(input longint mv);
    return 24'(longint'(sacq_pkg::CODE_MID) +
               (mv * longint'(2 ** 23)) / sacq_pkg::FS_MV);
  endfunction

  function automatic logic [3:0] max_len(input logic [1:0] v);
    logic [3:0] m;
    m = sacq_pkg::LEN_BASE;
    if (v == sacq_pkg::VAR_AO) begin
      m = sacq_pkg::LEN_AO;
    end else if (v == sacq_pkg::VAR_NOAO) begin
      m = sacq_pkg::LEN_NOAO;
    end
    return m;
  endfunction

  function automatic logic code_ok(input logic [1:0] v,
                                   input logic [2:0] c);
    logic ok;
    ok = (c <= sacq_pkg::CH_TACH0);
    if (v == sacq_pkg::VAR_AO) begin
      ok = 1'b1;
    end else if (v == sacq_pkg::VAR_NOAO) begin
      ok = (c <= sacq_pkg::CH_GATE2);
    end
    return ok;
  endfunction

  function automatic logic [2:0] entry(input logic [23:0] l,
                                       input logic [3:0] i);
    return l[i[2:0]*3 +: 3];
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_s1, pin_s2, pin_s3;
  logic [3:0] next_pin_s1, next_pin_s2, next_pin_s3;
  logic [3:0] pin_rise;

  always_comb begin
    next_pin_s1 = {sync_clk_i, sync_trig_i, ext_trig_i, smp_clk_i};
    next_pin_s2 = pin_s1;
    next_pin_s3 = pin_s2;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
      pin_s3 <= next_pin_s3;
    end
  end

  assign pin_rise = pin_s2 & ~pin_s3;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  sacq_state_e state, next_state;
  logic [1:0] ctrl_var, next_ctrl_var;
  logic [1:0] ctrl_trg, next_ctrl_trg;
  logic ctrl_slave, next_ctrl_slave;
  logic [6:0] thr_steps, next_thr_steps;
  logic [3:0] list_len, next_list_len;
  logic [23:0] list_codes, next_list_codes;
  logic [15:0] buf_len, next_buf_len;
  logic cfg_open, list_ok;

  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  // changing the list mid-scan would reorder samples
  assign cfg_open = (state == S_IDLE) || (state == S_DONE);

  always_comb begin
    next_ctrl_var = ctrl_var;
    next_ctrl_trg = ctrl_trg;
    next_ctrl_slave = ctrl_slave;
    next_thr_steps = thr_steps;
    next_list_len = list_len;
    next_list_codes = list_codes;
    next_buf_len = buf_len;
    if (cfg_open && wr_hit(sacq_pkg::REG_CTRL)) begin
      next_ctrl_var = reg_wdata_i[sacq_pkg::CTRL_VAR_LSB +: 2];
      next_ctrl_trg = reg_wdata_i[sacq_pkg::CTRL_TRG_LSB +: 2];
      next_ctrl_slave = reg_wdata_i[sacq_pkg::CTRL_SLAVE_BIT];
    end
    if (cfg_open && wr_hit(sacq_pkg::REG_THRESH)) begin
      next_thr_steps = reg_wdata_i[6:0];
    end
    if (cfg_open && wr_hit(sacq_pkg::REG_LIST_LEN)) begin
      next_list_len = reg_wdata_i[3:0];
    end
    if (cfg_open && wr_hit(sacq_pkg::REG_LIST)) begin
      next_list_codes = reg_wdata_i[23:0];
    end
    if (cfg_open && wr_hit(sacq_pkg::REG_BUF_LEN)) begin
      next_buf_len = reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_var <= sacq_pkg::VAR_BASE;
      ctrl_trg <= sacq_pkg::TRG_SW;
      ctrl_slave <= 1'b0;
      thr_steps <= sacq_pkg::RST_THR_STEPS;
      list_len <= sacq_pkg::RST_LIST_LEN;
      list_codes <= sacq_pkg::RST_LIST;
      buf_len <= sacq_pkg::RST_BUF_LEN;
    end else begin
      ctrl_var <= next_ctrl_var;
      ctrl_trg <= next_ctrl_trg;
      ctrl_slave <= next_ctrl_slave;
      thr_steps <= next_thr_steps;
      list_len <= next_list_len;
      list_codes <= next_list_codes;
      buf_len <= next_buf_len;
    end
  end

  // list length and codes checked before arming
  always_comb begin
    list_ok = (list_len != 4'h0) && (list_len <= max_len(ctrl_var)) &&
              (buf_len != 16'h0000);
    for (int i = 0; i < sacq_pkg::LIST_MAX; i++) begin
      if (4'(i) < list_len && !code_ok(ctrl_var, entry(list_codes, 4'(i))))
      begin
        list_ok = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sample clock, triggers and threshold
  // ---------------------------------------------------------------
  logic eff_slave, smp_pulse, trig_ev, thr_fire, grp_done;
  logic thr_below, next_thr_below;
  logic [5:0] grp_cnt, next_grp_cnt;
  logic [23:0] ch0_code, thr_level, thr_rearm;
  logic [6:0] steps_c;

  // slave mode uses the link for clock and trigger
  assign eff_slave = ctrl_slave && (ctrl_var != sacq_pkg::VAR_BASE);
  // one scan per sample clock edge
  assign smp_pulse = eff_slave ? pin_rise[3] : pin_rise[0];
  assign grp_done = (grp_cnt == sacq_pkg::GRP_DELAY);

  // channel 0 watched regardless of the list
  assign ch0_code = sat24(adc0_i);

  always_comb begin
    steps_c = thr_steps;
    if (thr_steps < sacq_pkg::THR_MIN_STEPS) begin
      steps_c = sacq_pkg::THR_MIN_STEPS;
    end else if (thr_steps > sacq_pkg::THR_MAX_STEPS) begin
      steps_c = sacq_pkg::THR_MAX_STEPS;
    end
    thr_level = mv_code(sacq_pkg::THR_FIXED_MV);
    thr_rearm = thr_level;
    if (ctrl_var != sacq_pkg::VAR_BASE) begin
      thr_level = mv_code(longint'(steps_c) * sacq_pkg::THR_STEP_MV);
      thr_rearm = mv_code(longint'(steps_c) * sacq_pkg::THR_STEP_MV -
                          sacq_pkg::HYST_MV);
    end
  end

  // converter output before the group delay is meaningless
  assign thr_fire = smp_pulse && grp_done && thr_below &&
                    (ch0_code > thr_level);
  always_comb begin
    next_thr_below = thr_below;
    if (smp_pulse && grp_done) begin
      if (ch0_code <= thr_rearm) begin
        next_thr_below = 1'b1;
      end else if (thr_fire) begin
        next_thr_below = 1'b0;
      end
    end
    next_grp_cnt = grp_cnt;
    if (state == S_IDLE) begin
      next_grp_cnt = 6'h00;
    // count out the converter group delay
    end else if (smp_pulse && !grp_done) begin
      next_grp_cnt = grp_cnt + 6'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_below <= 1'b0;
      grp_cnt <= 6'h00;
    end else begin
      thr_below <= next_thr_below;
      grp_cnt <= next_grp_cnt;
    end
  end

  logic cmd_wr, cmd_arm, cmd_start, cmd_orderly, cmd_abrupt;
  // spelled out: an assign only wakes on its arguments
  assign cmd_wr = reg_wr_i && (reg_addr_i == sacq_pkg::REG_CMD);
  assign cmd_arm = cmd_wr && reg_wdata_i[sacq_pkg::CMD_ARM_BIT];
  assign cmd_start = cmd_wr && reg_wdata_i[sacq_pkg::CMD_START_BIT];
  assign cmd_orderly = cmd_wr && reg_wdata_i[sacq_pkg::CMD_ORDERLY_BIT];
  assign cmd_abrupt = cmd_wr && reg_wdata_i[sacq_pkg::CMD_ABRUPT_BIT];

  always_comb begin
    trig_ev = 1'b0;
    if (eff_slave) begin
      trig_ev = pin_rise[2];
    end else if (ctrl_trg == sacq_pkg::TRG_SW) begin
      trig_ev = cmd_start;
    end else if (ctrl_trg == sacq_pkg::TRG_EXT) begin
      trig_ev = pin_rise[1];
    end else if (ctrl_trg == sacq_pkg::TRG_THR) begin
      trig_ev = thr_fire;
    end
  end

  // ---------------------------------------------------------------
  // acquisition control and stream
  // ---------------------------------------------------------------
  logic [7:0] queue_cnt, next_queue_cnt;
  logic [15:0] scan_cnt, next_scan_cnt;
  logic [3:0] emit_idx, next_emit_idx;
  logic emitting, next_emitting, orderly_pend, next_orderly_pend;
  logic ovr_st, next_ovr_st, part_st, next_part_st;
  logic [23:0] snap [0:7];
  logic [23:0] next_snap [0:7];
  logic q_inc, q_dec;
  logic next_valid, next_eos, next_bdone, next_part, next_ovr, next_busy;
  logic [23:0] next_data;
  logic [2:0] next_chan, cur_code;

  assign cur_code = entry(list_codes, emit_idx);

  always_comb begin
    next_state = state;
    next_scan_cnt = scan_cnt;
    next_emit_idx = emit_idx;
    next_emitting = emitting;
    next_orderly_pend = orderly_pend;
    next_ovr_st = ovr_st;
    next_part_st = part_st;
    next_snap = snap;
    next_valid = 1'b0;
    next_eos = 1'b0;
    next_bdone = 1'b0;
    next_part = 1'b0;
    next_ovr = 1'b0;
    next_data = smp_data_o;
    next_chan = smp_chan_o;
    q_inc = wr_hit(sacq_pkg::REG_QUEUE) && (queue_cnt != 8'hFF);
    q_dec = 1'b0;
    unique case (state)
      S_IDLE, S_DONE: begin
        // only an arm opens the door to triggers
        if (cmd_arm && list_ok) begin
          next_state = S_ARMED;
          next_scan_cnt = 16'h0000;
          next_orderly_pend = 1'b0;
          next_ovr_st = 1'b0;
          next_part_st = 1'b0;
          next_emitting = 1'b0;
        end
      end
      S_ARMED: begin
        if (cmd_abrupt || cmd_orderly) begin
          next_state = S_DONE;
        end else if (trig_ev) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (cmd_abrupt) begin
          // stop now, hand back the partial buffer
          next_state = S_DONE;
          next_emitting = 1'b0;
          if (scan_cnt != 16'h0000 || emitting) begin
            next_bdone = 1'b1;
            next_part = 1'b1;
            next_part_st = 1'b1;
            q_dec = 1'b1;
          end
        end else if (emitting) begin
          next_valid = 1'b1;
          next_chan = cur_code;
          next_data = snap[cur_code];
          next_emit_idx = emit_idx + 4'h1;
          if (cmd_orderly) begin
            next_orderly_pend = 1'b1;
          end
          if (emit_idx == list_len - 4'h1) begin
            next_emitting = 1'b0;
            next_eos = 1'b1;
            next_scan_cnt = scan_cnt + 16'h0001;
            if (scan_cnt + 16'h0001 == buf_len) begin
              next_scan_cnt = 16'h0000;
              next_bdone = 1'b1;
              q_dec = 1'b1;
              // orderly stop ends on a buffer boundary
              if (orderly_pend || cmd_orderly) begin
                next_state = S_DONE;
              end
            end
          end
        end else if (cmd_orderly && scan_cnt == 16'h0000) begin
          next_state = S_DONE;
        end else begin
          if (cmd_orderly) begin
            next_orderly_pend = 1'b1;
          end
          if (smp_pulse && grp_done) begin
            if (queue_cnt == 8'h00) begin
              // no buffer left for this scan
              next_state = S_DONE;
              next_ovr = 1'b1;
              next_ovr_st = 1'b1;
            end else begin
              // all sources latched on the same edge
              next_emitting = 1'b1;
              next_emit_idx = 4'h0;
              next_snap[0] = sat24(adc0_i);
              next_snap[1] = sat24(adc1_i);
              next_snap[2] = sat24(adc2_i);
              next_snap[3] = sat24(adc3_i);
              next_snap[4] = tach0_i;
              next_snap[5] = tach1_i;
              next_snap[6] = gate2_i;
              // readback is an analog value too
              next_snap[7] = sat24(ao_rb_i);
            end
          end
        end
      end
    endcase
    // host queue counts down as buffers fill
    next_queue_cnt = queue_cnt + {7'h00, q_inc} - {7'h00, q_dec};
    next_busy = (next_state == S_ARMED) || (next_state == S_RUN);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      queue_cnt <= 8'h00;
      scan_cnt <= 16'h0000;
      emit_idx <= 4'h0;
      emitting <= 1'b0;
      orderly_pend <= 1'b0;
      ovr_st <= 1'b0;
      part_st <= 1'b0;
      for (int i = 0; i < sacq_pkg::LIST_MAX; i++) begin
        snap[i] <= 24'h00_0000;
      end
      smp_valid_o <= 1'b0;
      smp_eos_o <= 1'b0;
      smp_data_o <= 24'h00_0000;
      smp_chan_o <= 3'h0;
      buf_done_o <= 1'b0;
      buf_part_o <= 1'b0;
      overrun_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      queue_cnt <= next_queue_cnt;
      scan_cnt <= next_scan_cnt;
      emit_idx <= next_emit_idx;
      emitting <= next_emitting;
      orderly_pend <= next_orderly_pend;
      ovr_st <= next_ovr_st;
      part_st <= next_part_st;
      snap <= next_snap;
      smp_valid_o <= next_valid;
      smp_eos_o <= next_eos;
      smp_data_o <= next_data;
      smp_chan_o <= next_chan;
      buf_done_o <= next_bdone;
      buf_part_o <= next_part;
      overrun_o <= next_ovr;
      busy_o <= next_busy;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sacq_pkg::REG_CTRL: next_rdata = {27'h000_0000, ctrl_slave,
                                          ctrl_trg, ctrl_var};
        sacq_pkg::REG_THRESH: next_rdata = {25'h000_0000, thr_steps};
        sacq_pkg::REG_LIST_LEN: next_rdata = {28'h000_0000, list_len};
        sacq_pkg::REG_LIST: next_rdata = {8'h00, list_codes};
        sacq_pkg::REG_BUF_LEN: next_rdata = {16'h0000, buf_len};
        sacq_pkg::REG_QUEUE: next_rdata = {24'h00_0000, queue_cnt};
        sacq_pkg::REG_STATUS: next_rdata = {scan_cnt, queue_cnt, 3'h0,
                                            !list_ok, part_st, ovr_st,
                                            2'(state)};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

// file: verif/sacq_ctrl_asserts.sv
`timescale 1ns/1ps
module sacq_ctrl_asserts (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic smp_valid_o,
  input wire logic smp_eos_o,
  input wire logic buf_done_o,
  input wire logic buf_part_o,
  input wire logic overrun_o,
  input wire logic busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_entry;
    smp_valid_o && !smp_eos_o;
  endsequence
  sequence s_cmd_write;
    reg_wr_i && reg_addr_i == sacq_pkg::REG_CMD;
  endsequence
  a_scan_contig: assert property (s_entry |=> smp_valid_o || !busy_o)
    else $error("scan entries not consecutive");
  a_eos_valid: assert property (smp_eos_o |-> smp_valid_o)
    else $error("end of scan without sample");
  a_done_eos: assert property (buf_done_o && !buf_part_o |-> smp_eos_o)
    else $error("full buffer not at end of scan");
  a_part_done: assert property (buf_part_o |-> buf_done_o)
    else $error("partial flag without buffer event");
  a_ovr_stop: assert property (overrun_o |-> !smp_valid_o ##1 !busy_o)
    else $error("overrun did not stop acquisition");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(reg_wr_i) &&
    $past(reg_addr_i) == sacq_pkg::REG_CMD)
    else $error("busy rose without command write");
  a_abrupt_halt: assert property (s_cmd_write ##0 busy_o &&
    reg_wdata_i[sacq_pkg::CMD_ABRUPT_BIT] |=> !busy_o)
    else $error("abrupt stop did not halt");
  a_idle_quiet: assert property (!busy_o [*3] |-> !smp_valid_o)
    else $error("sample delivered while stopped");
endmodule

bind sacq_ctrl sacq_ctrl_asserts u_chk (
  .mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .smp_valid_o,
  .smp_eos_o, .buf_done_o, .buf_part_o, .overrun_o, .busy_o
);

// file: verif/sacq_host.sv
`timescale 1ns/1ps
module sacq_host (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // stream and events from the block
  input wire logic smp_valid_i,
  input wire logic [23:0] smp_data_i,
  input wire logic [2:0] smp_chan_i,
  input wire logic smp_eos_i,
  input wire logic buf_done_i,
  input wire logic buf_part_i,
  input wire logic overrun_i
);
  logic [26:0] rx_q[$];
  int n_scan = 0;
  int n_buf = 0;
  int n_part = 0;
  int n_ovr = 0;
  // never stalls: a slow host shows as overrun
  always @(posedge mclk_i) begin
    if (!rst_i && smp_valid_i) rx_q.push_back({smp_chan_i, smp_data_i});
    n_scan <= n_scan + int'(smp_eos_i);
    n_buf <= n_buf + int'(buf_done_i);
    n_part <= n_part + int'(buf_part_i);
    n_ovr <= n_ovr + int'(overrun_i);
  end
endmodule

// file: verif/sacq_ctrl_test.sv
`timescale 1ns/1ps
module sacq_ctrl_test;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic smp_clk_i = 1'b0;
  logic ext_trig_i = 1'b0;
  logic sync_trig_i = 1'b0;
  logic sync_clk_i = 1'b0;
  logic signed [25:0] adc0_i = 26'sh80_0000;
  logic signed [25:0] adc1_i = -26'sh80_0001;
  logic signed [25:0] adc2_i = 26'sh0;
  logic signed [25:0] adc3_i = 26'sh12_3456;
  logic signed [25:0] ao_rb_i = -26'sh1;
  logic [23:0] tach0_i = 24'h111;
  logic [23:0] tach1_i = 24'h222;
  logic [23:0] gate2_i = 24'h333;
  logic [31:0] reg_rdata_o;
  logic [23:0] smp_data_o;
  logic [2:0] smp_chan_o;
  logic smp_valid_o, smp_eos_o, buf_done_o, buf_part_o, overrun_o, busy_o;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  sacq_ctrl u_dut (
    .mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .smp_clk_i, .ext_trig_i, .sync_trig_i, .sync_clk_i,
    .adc0_i, .adc1_i, .adc2_i, .adc3_i, .ao_rb_i, .tach0_i, .tach1_i,
    .gate2_i, .smp_valid_o, .smp_data_o, .smp_chan_o, .smp_eos_o,
    .buf_done_o, .buf_part_o, .overrun_o, .busy_o
  );
  sacq_host u_host (
    .mclk_i, .rst_i, .smp_valid_i(smp_valid_o), .smp_data_i(smp_data_o),
    .smp_chan_i(smp_chan_o), .smp_eos_i(smp_eos_o),
    .buf_done_i(buf_done_o), .buf_part_i(buf_part_o), .overrun_i(overrun_o)
  );
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic st(input logic [7:0] e);
    logic [31:0] d;
    rd(sacq_pkg::REG_STATUS, d);
    chk({24'h0, d[7:0]}, {24'h0, e});
    chk({31'h0, busy_o}, {31'h0, ^e[1:0]});
  endtask
  task automatic cfg(input logic [31:0] c, l, s, b, input int q);
    wr(sacq_pkg::REG_CTRL, c);
    wr(sacq_pkg::REG_LIST_LEN, l);
    wr(sacq_pkg::REG_LIST, s);
    wr(sacq_pkg::REG_BUF_LEN, b);
    repeat (q) wr(sacq_pkg::REG_QUEUE, 32'h1);
  endtask
  // pulses are far apart: a whole scan must drain between them
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      smp_clk_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      smp_clk_i <= 1'b0;
      repeat (15) @(posedge mclk_i);
    end
  endtask
  task automatic epulse();
    @(posedge mclk_i);
    ext_trig_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    ext_trig_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic arm();
    wr(sacq_pkg::REG_CMD, 32'h1);
    pulses(40);
  endtask
  function automatic logic [23:0] code_of(input logic signed [25:0] r);
    if (r > 26'sh7F_FFFF) return 24'hFF_FFFF;
    if (r < -26'sh80_0000) return 24'h0;
    return r[23:0] ^ 24'h80_0000;
  endfunction
  function automatic logic [23:0] exp_of(input logic [2:0] c);
    case (c)
      3'h0: return code_of(adc0_i);
      3'h1: return code_of(adc1_i);
      3'h2: return code_of(adc2_i);
      3'h3: return code_of(adc3_i);
      3'h4: return tach0_i;
      3'h5: return tach1_i;
      3'h6: return gate2_i;
      default: return code_of(ao_rb_i);
    endcase
  endfunction
  task automatic drain(input logic [23:0] l, input int n, input int ns);
    logic [26:0] v;
    logic [2:0] c;
    repeat (ns) for (int i = 0; i < n; i++) begin
      c = l[3*i +: 3];
      v = u_host.rx_q.size() > 0 ? u_host.rx_q.pop_front() : 27'h0;
      chk({5'h0, v}, {5'h0, c, exp_of(c)});
    end
    chk(u_host.rx_q.size(), 32'h0);
  endtask
  task automatic tally(input int s, b, p, o);
    chk(u_host.n_scan, s);
    chk(u_host.n_buf, b);
    chk(u_host.n_part, p);
    chk(u_host.n_ovr, o);
  endtask
  task automatic t_cfg();
    logic [31:0] d;
    logic [31:0] rows [5] = '{32'h8600_4688, 32'h8500_468D,
      32'h271A_C688, 32'hA81A_C688, 32'h18FA_C688};
    rd(8'h20, d);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      cfg({30'h0, rows[i][29:28]}, {28'h0, rows[i][27:24]},
        {8'h0, rows[i][23:0]}, 32'h100, 0);
      rd(sacq_pkg::REG_STATUS, d);
      chk({31'h0, d[4]}, {31'h0, rows[i][31]});
    end
  endtask
  task automatic t_run();
    cfg(32'h1, 32'h8, 32'hAB_19C3, 32'h2, 2);
    arm();
    st(8'h01);
    wr(sacq_pkg::REG_CMD, 32'h2);
    pulses(4);
    tally(4, 2, 0, 0);
    drain(24'hAB_19C3, 8, 4);
    pulses(1);
    tally(4, 2, 0, 1);
    st(8'h07);
  endtask
  task automatic t_abrupt();
    cfg(32'h4, 32'h5, 32'h4688, 32'h4, 1);
    epulse();
    arm();
    st(8'h01);
    epulse();
    pulses(1);
    wr(sacq_pkg::REG_CMD, 32'h8);
    epulse();
    pulses(2);
    tally(5, 3, 1, 1);
    st(8'h0B);
    drain(24'h4688, 5, 1);
  endtask
  task automatic t_orderly();
    cfg(32'h8, 32'h5, 32'h4688, 32'h2, 2);
    adc0_i <= 26'sh0;
    arm();
    adc0_i <= 26'sh80_0000;
    pulses(2);
    wr(sacq_pkg::REG_CMD, 32'h4);
    pulses(2);
    wr(sacq_pkg::REG_CMD, 32'h2);
    pulses(1);
    tally(7, 4, 1, 1);
    st(8'h03);
    drain(24'h4688, 5, 2);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_cfg();
    t_run();
    t_abrupt();
    t_orderly();
    give_verdict();
  end
endmodule
